// [hdl/imr_consts.svh]
// Register offsets, field positions and reset values for the I2C master port
`ifndef IMR_CONSTS_SVH
`define IMR_CONSTS_SVH
`define IMR_ADDR_W 4
`define IMR_OFF_CTRL 4'h0
`define IMR_OFF_STAT 4'h4
`define IMR_OFF_BUF 4'h8
`define IMR_OFF_BAUD 4'hc
`define IMR_CTL_START 0
`define IMR_CTL_STOP 1
`define IMR_CTL_RECV 2
`define IMR_CTL_ACKSEQ 3
`define IMR_CTL_ACKDATA 4
`define IMR_CTL_IRQEN 5
`define IMR_CTL_PORTEN 7
`define IMR_ST_BF 0
`define IMR_ST_OVF 1
`define IMR_ST_WRITE_COLLISION 2
`define IMR_ST_BCOL 3
`define IMR_ST_IRQ 4
`define IMR_ST_STOPDET 5
`define IMR_ST_STARTDET 6
`define IMR_ST_ACKSTAT 7
`define IMR_BAUD_RST 8'h09
`define IMR_LAST_DATA_BIT 4'h7
`define IMR_ACK_BIT 4'h8
`endif

// [hdl/imr_pkg.sv]
// Types shared by the I2C master port
package imr_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_TX    = 6'h04,
    ST_RX    = 6'h08,
    ST_ACK   = 6'h10,
    ST_STOP  = 6'h20
  } imr_state_type;
endpackage

// [hdl/imr_brg_if.sv]
// Control and tick signals between the port sequencer and its baud generator
`timescale 1ns/10ps
interface imr_brg_if #(parameter int W = 8);
  logic load;
  logic run;
  logic [W-1:0] reload;
  logic tick;
  modport ctl (output load, output run, output reload, input tick);
  modport gen (input load, input run, input reload, output tick);
endinterface

// [hdl/imr_brg.sv]
// Reloadable baud generator: one tick per half bus clock period
`timescale 1ns/10ps
module imr_brg (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Sequencer side
  imr_brg_if.gen brg
);
  localparam int W = $bits(brg.reload);
  logic [W:0] cnt_r;
  logic [W:0] cnt_nxt;
  logic [W:0] load_val;
  logic at_zero;

  // Twice the reload plus one, counted to zero: 2*(reload+1) clocks per half period
  assign load_val = {brg.reload, 1'b1};
  assign at_zero = (cnt_r == '0);
  assign brg.tick = brg.run && !brg.load && at_zero;

  always_comb begin
    cnt_nxt = cnt_r;
    if (brg.load || (brg.run && at_zero)) begin
      cnt_nxt = load_val;
    end else if (brg.run) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // imr_brg

// [hdl/imr_top.sv]
// I2C master port: receive, acknowledge, stop, transmit and arbitration
// Notes on behaviour
// - Receive enable written while the port is not idle is ignored.
// - In receive, every baud tick toggles SCL and SDA is shifted in.
// - After the eighth bit, clear enable, load buffer, set flags, hold SCL low.
// - Buffer full sets when a byte lands in the buffer, clears on read.
// - Overflow sets when a byte completes while buffer full is still set.
// - Buffer write during any sequence sets write collision, buffer unchanged.
// - Ack sequence pulls SCL low and drives the ack data bit on SDA.
// - Ack: one period, release SCL, wait high, one period, SCL low, idle.
// - Stop: SDA low, reload generator, release SCL, one period later release SDA.
// - SDA high with SCL high sets stop detected; one period later done, flag.
// - While asleep, a flagged event wakes the processor if interrupts enabled.
// - Reset disables the port and aborts any transfer.
// - Start and stop detected clear on reset or when the port is disabled.
// - With bus busy and interrupt enabled, the next stop raises the flag.
// - With SCL high, driven one but sampled zero sets collision, goes idle.
// - Collision in transmit halts shifting, clears buffer full, frees lines.
// - Collision in a sequence aborts it, frees lines, clears its enable.
// - After a collision, a stop seen on the bus sets the port flag.
// - A buffer write after collision restarts at the first bit.
// - Generator reloads from the 8-bit register; bus clock is clk/(4*(n+1)).
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "imr_consts.svh"
module imr_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [`IMR_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // I2C lines
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  // System
  input wire logic i_sleep,
  output logic o_wake
);
  imr_pkg::imr_state_type state_r, state_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] buf_r, buf_nxt;
  logic [7:0] baud_r, baud_nxt;
  logic bf_r, bf_nxt, ovf_r, ovf_nxt, write_collision_r, write_collision_nxt, bcol_r, bcol_nxt;
  logic irq_r, irq_nxt, pdet_r, pdet_nxt, sdet_r, sdet_nxt, ackst_r, ackst_nxt;
  logic sen_r, sen_nxt, pen_r, pen_nxt, receive_enable_bit_r, receive_enable_bit_nxt, ack_sequence_enable_r, ack_sequence_enable_nxt;
  logic ack_data_value_r, ack_data_value_nxt, irqen_r, irqen_nxt, porten_r, porten_nxt;
  logic sda_low_r, sda_low_nxt, scl_low_r, scl_low_nxt;
  logic collided_r, collided_nxt, sda_q_r, scl_q_r, wake_r, wait_r, zero_r;
  logic [31:0] rdata_r;
  logic collide;
  logic brg_load;

  // Bus decode
  wire req = i_avs_read | i_avs_write;
  wire wr_go = i_avs_write & ~wait_r;
  wire rd_go = i_avs_read & ~wait_r;
  wire sel_ctrl = (i_avs_address == `IMR_OFF_CTRL);
  wire sel_stat = (i_avs_address == `IMR_OFF_STAT);
  wire sel_buf = (i_avs_address == `IMR_OFF_BUF);
  wire sel_baud = (i_avs_address == `IMR_OFF_BAUD);
  wire wr_ctrl = wr_go & sel_ctrl;
  wire wr_stat = wr_go & sel_stat;
  wire wr_buf = wr_go & sel_buf;
  wire wr_baud = wr_go & sel_baud;
  wire rd_buf = rd_go & sel_buf;
  wire [7:0] wd = i_avs_writedata[7:0];
  wire idle = (state_r == imr_pkg::ST_IDLE);
  wire cmd_pend = sen_r | pen_r | receive_enable_bit_r | ack_sequence_enable_r;
  wire cmd_ok = idle & porten_r & ~cmd_pend;
  // A write is taken only between sequences; anything else is a collision
  wire buf_take = wr_buf & cmd_ok;
  wire tick;

  // Bus monitor, one sample of history on each line
  wire start_ev = scl_q_r & i_scl & sda_q_r & ~i_sda;
  wire stop_ev = scl_q_r & i_scl & ~sda_q_r & i_sda;

  wire [7:0] ctrl_word = {porten_r, 1'b0, irqen_r, ack_data_value_r, ack_sequence_enable_r, receive_enable_bit_r, pen_r, sen_r};
  wire [7:0] stat_word = {ackst_r, sdet_r, pdet_r, irq_r, bcol_r, write_collision_r, ovf_r, bf_r};
  wire [7:0] rd_byte = sel_ctrl ? ctrl_word :
                       sel_stat ? stat_word :
                       sel_buf ? buf_r :
                       sel_baud ? baud_r : 8'h00;

  imr_brg_if #(.W(8)) brg_bus ();
  assign brg_bus.load = brg_load;
  assign brg_bus.run = ~idle;
  assign brg_bus.reload = baud_r;
  assign tick = brg_bus.tick;

  imr_brg u_brg (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .brg(brg_bus)
  );

  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    buf_nxt = buf_r;
    baud_nxt = baud_r;
    bf_nxt = bf_r;
    ovf_nxt = ovf_r;
    write_collision_nxt = write_collision_r;
    bcol_nxt = bcol_r;
    irq_nxt = irq_r;
    pdet_nxt = pdet_r;
    sdet_nxt = sdet_r;
    ackst_nxt = ackst_r;
    sen_nxt = sen_r;
    pen_nxt = pen_r;
    receive_enable_bit_nxt = receive_enable_bit_r;
    ack_sequence_enable_nxt = ack_sequence_enable_r;
    ack_data_value_nxt = ack_data_value_r;
    irqen_nxt = irqen_r;
    porten_nxt = porten_r;
    sda_low_nxt = sda_low_r;
    scl_low_nxt = scl_low_r;
    collided_nxt = collided_r;
    collide = 1'b0;
    brg_load = 1'b0;
    // Software side first, so that hardware sets below win over clears
    if (wr_ctrl) begin
      ack_data_value_nxt = wd[`IMR_CTL_ACKDATA];
      irqen_nxt = wd[`IMR_CTL_IRQEN];
      porten_nxt = wd[`IMR_CTL_PORTEN];
      // No queueing: commands land only while idle with none pending
      if (cmd_ok) begin
        sen_nxt = wd[`IMR_CTL_START];
        pen_nxt = wd[`IMR_CTL_STOP];
        receive_enable_bit_nxt = wd[`IMR_CTL_RECV];
        ack_sequence_enable_nxt = wd[`IMR_CTL_ACKSEQ];
      end
    end
    if (wr_stat) begin
      ovf_nxt = ovf_r & ~wd[`IMR_ST_OVF];
      write_collision_nxt = write_collision_r & ~wd[`IMR_ST_WRITE_COLLISION];
      bcol_nxt = bcol_r & ~wd[`IMR_ST_BCOL];
      irq_nxt = irq_r & ~wd[`IMR_ST_IRQ];
    end
    if (wr_baud) begin
      baud_nxt = wd;
    end
    if (rd_buf) begin
      bf_nxt = 1'b0;
    end
    if (wr_buf && !buf_take) begin
      write_collision_nxt = 1'b1;
    end
    case (state_r)
      imr_pkg::ST_IDLE: begin
        if (porten_r && sen_r) begin
          state_nxt = imr_pkg::ST_START;
          phase_nxt = 2'h0;
          brg_load = 1'b1;
        end else if (porten_r && pen_r) begin
          state_nxt = imr_pkg::ST_STOP;
          phase_nxt = 2'h0;
          sda_low_nxt = 1'b1;
          scl_low_nxt = 1'b1;
        end else if (porten_r && receive_enable_bit_r) begin
          state_nxt = imr_pkg::ST_RX;
          phase_nxt = 2'h0;
          bit_nxt = 4'h0;
          brg_load = 1'b1;
          sda_low_nxt = 1'b0;
          scl_low_nxt = 1'b1;
        end else if (porten_r && ack_sequence_enable_r) begin
          state_nxt = imr_pkg::ST_ACK;
          phase_nxt = 2'h0;
          brg_load = 1'b1;
          sda_low_nxt = ~ack_data_value_r;
          scl_low_nxt = 1'b1;
        end else if (buf_take) begin
          // Always from the top bit, wherever an earlier byte stopped
          state_nxt = imr_pkg::ST_TX;
          phase_nxt = 2'h0;
          bit_nxt = 4'h0;
          shift_nxt = wd;
          buf_nxt = wd;
          bf_nxt = 1'b1;
          brg_load = 1'b1;
          scl_low_nxt = 1'b1;
          sda_low_nxt = ~wd[7];
        end
      end
      imr_pkg::ST_START: begin
        if (phase_r == 2'h0) begin
          if (!i_sda || !i_scl) begin
            collide = 1'b1;
          end else if (tick) begin
            sda_low_nxt = 1'b1;
            phase_nxt = 2'h1;
          end
        end else if (tick) begin
          scl_low_nxt = 1'b1;
          sen_nxt = 1'b0;
          irq_nxt = 1'b1;
          state_nxt = imr_pkg::ST_IDLE;
        end
      end
      imr_pkg::ST_TX: begin
        if (phase_r == 2'h0) begin
          if (tick) begin
            scl_low_nxt = 1'b0;
            phase_nxt = 2'h1;
          end
        end else if (!i_scl) begin
          // Clock stretching: the high half starts when SCL is really high
          brg_load = 1'b1;
        end else if (!sda_low_r && !i_sda && bit_r != `IMR_ACK_BIT) begin
          collide = 1'b1;
        end else if (tick) begin
          scl_low_nxt = 1'b1;
          if (bit_r == `IMR_ACK_BIT) begin
            ackst_nxt = i_sda;
            irq_nxt = 1'b1;
            state_nxt = imr_pkg::ST_IDLE;
          end else begin
            bit_nxt = bit_r + 4'h1;
            shift_nxt = {shift_r[6:0], 1'b0};
            phase_nxt = 2'h0;
            if (bit_r == `IMR_LAST_DATA_BIT) begin
              bf_nxt = 1'b0;
              sda_low_nxt = 1'b0;
            end else begin
              sda_low_nxt = ~shift_r[6];
            end
          end
        end
      end
      imr_pkg::ST_RX: begin
        if (phase_r == 2'h0) begin
          if (tick) begin
            scl_low_nxt = 1'b0;
            phase_nxt = 2'h1;
          end
        end else if (!i_scl) begin
          brg_load = 1'b1;
        end else if (tick) begin
          shift_nxt = {shift_r[6:0], i_sda};
          scl_low_nxt = 1'b1;
          if (bit_r == `IMR_LAST_DATA_BIT) begin
            receive_enable_bit_nxt = 1'b0;
            buf_nxt = {shift_r[6:0], i_sda};
            bf_nxt = 1'b1;
            ovf_nxt = ovf_r | bf_r;
            irq_nxt = 1'b1;
            state_nxt = imr_pkg::ST_IDLE;
          end else begin
            bit_nxt = bit_r + 4'h1;
            phase_nxt = 2'h0;
          end
        end
      end
      imr_pkg::ST_ACK: begin
        if (phase_r == 2'h0) begin
          if (tick) begin
            scl_low_nxt = 1'b0;
            phase_nxt = 2'h1;
          end
        end else if (!i_scl) begin
          brg_load = 1'b1;
        end else if (ack_data_value_r && !i_sda) begin
          collide = 1'b1;
        end else if (tick) begin
          scl_low_nxt = 1'b1;
          ack_sequence_enable_nxt = 1'b0;
          irq_nxt = 1'b1;
          state_nxt = imr_pkg::ST_IDLE;
        end
      end
      imr_pkg::ST_STOP: begin
        case (phase_r)
          2'h0: begin
            if (!i_sda) begin
              brg_load = 1'b1;
              phase_nxt = 2'h1;
            end
          end
          2'h1: begin
            if (tick) begin
              scl_low_nxt = 1'b0;
              phase_nxt = 2'h2;
            end
          end
          2'h2: begin
            if (!i_scl) begin
              brg_load = 1'b1;
            end else if (tick) begin
              sda_low_nxt = 1'b0;
              phase_nxt = 2'h3;
            end
          end
          default: begin
            if (!i_scl) begin
              collide = 1'b1;
            end else if (tick) begin
              if (!i_sda) begin
                collide = 1'b1;
              end else begin
                pen_nxt = 1'b0;
                irq_nxt = 1'b1;
                state_nxt = imr_pkg::ST_IDLE;
              end
            end else if (i_sda) begin
              pdet_nxt = 1'b1;
            end
          end
        endcase
      end
      default: begin
        state_nxt = imr_pkg::ST_IDLE;
      end
    endcase
    if (collide) begin
      state_nxt = imr_pkg::ST_IDLE;
      bcol_nxt = 1'b1;
      sda_low_nxt = 1'b0;
      scl_low_nxt = 1'b0;
      sen_nxt = 1'b0;
      pen_nxt = 1'b0;
      ack_sequence_enable_nxt = 1'b0;
      collided_nxt = 1'b1;
      if (state_r == imr_pkg::ST_TX) begin
        bf_nxt = 1'b0;
      end
    end
    if (start_ev) begin
      sdet_nxt = 1'b1;
      pdet_nxt = 1'b0;
    end
    if (stop_ev) begin
      sdet_nxt = 1'b0;
      pdet_nxt = 1'b1;
      collided_nxt = 1'b0;
      if ((irqen_r && sdet_r) || collided_r) begin
        irq_nxt = 1'b1;
      end
    end
    // Disabling aborts any transfer and frees the bus
    if (!porten_r) begin
      state_nxt = imr_pkg::ST_IDLE;
      sda_low_nxt = 1'b0;
      scl_low_nxt = 1'b0;
      sdet_nxt = 1'b0;
      pdet_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= imr_pkg::ST_IDLE;
      phase_r <= 2'h0;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      buf_r <= 8'h00;
      baud_r <= `IMR_BAUD_RST;
      {bf_r, ovf_r, write_collision_r, bcol_r, irq_r, ackst_r} <= 6'h00;
      {pdet_r, sdet_r} <= 2'h0;
      {sen_r, pen_r, receive_enable_bit_r, ack_sequence_enable_r, ack_data_value_r, irqen_r} <= 6'h00;
      porten_r <= 1'b0;
      {sda_low_r, scl_low_r, collided_r} <= 3'h0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      buf_r <= buf_nxt;
      baud_r <= baud_nxt;
      {bf_r, ovf_r, write_collision_r, bcol_r} <= {bf_nxt, ovf_nxt, write_collision_nxt, bcol_nxt};
      {irq_r, ackst_r, pdet_r, sdet_r} <= {irq_nxt, ackst_nxt, pdet_nxt, sdet_nxt};
      {sen_r, pen_r, receive_enable_bit_r, ack_sequence_enable_r} <= {sen_nxt, pen_nxt, receive_enable_bit_nxt, ack_sequence_enable_nxt};
      {ack_data_value_r, irqen_r, porten_r} <= {ack_data_value_nxt, irqen_nxt, porten_nxt};
      {sda_low_r, scl_low_r, collided_r} <= {sda_low_nxt, scl_low_nxt, collided_nxt};
    end
  end

  // Bus answer one cycle after the request; wake is a plain level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      {sda_q_r, scl_q_r} <= 2'h3;
      wake_r <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      wait_r <= ~(req & wait_r);
      if (i_avs_read && wait_r) begin
        rdata_r <= {24'h00_0000, rd_byte};
      end
      {sda_q_r, scl_q_r} <= {i_sda, i_scl};
      // Slave address match is not in this block; any flagged event wakes when interrupts are enabled
      wake_r <= i_sleep & irqen_r & irq_r;
      zero_r <= 1'b0;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  // Open drain: the data level is always low, only the enable moves
  assign o_sda_out = zero_r;
  assign o_scl_out = zero_r;
  assign o_sda_oe = sda_low_r;
  assign o_scl_oe = scl_low_r;
  assign o_wake = wake_r;
endmodule // imr_top

// [testbench/imr_top_sva.sv]
// Port-level assertions and covers for the I2C master port
`timescale 1ns/10ps
`include "imr_consts.svh"
module imr_top_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register bus
  input wire logic [`IMR_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // I2C lines
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_scl,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  // System
  input wire logic i_sleep,
  input wire logic o_wake
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_wait_pulse: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("waitrequest pulse wrong");
  a_read_upper: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_read: assert property (i_avs_read && !o_avs_waitrequest
    && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0) else $error("unmapped read");
  a_outs_low: assert property (o_sda_out == 1'b0 && o_scl_out == 1'b0)
    else $error("line driven high");
  a_rst_release: assert property ($fell(i_rst) |-> !o_sda_oe && !o_scl_oe && !o_wake)
    else $error("lines held after reset");
  a_wake_sleep: assert property (o_wake |-> $past(i_sleep))
    else $error("wake without sleep");
  // Pulling SCL low before it is seen high would defeat clock stretching
  a_scl_arbit: assert property ($rose(o_scl_oe) |-> $past(i_scl))
    else $error("scl pulled before seen high");
  a_scl_hold: assert property ($rose(o_scl_oe) |=> o_scl_oe)
    else $error("scl low phase too short");
  a_stop_order: assert property ($fell(o_sda_oe) && !$past(o_scl_oe)
    |-> !$past(o_scl_oe, 2)) else $error("sda freed too soon after scl");
  c_start: cover property ($rose(o_sda_oe) && i_scl && !o_scl_oe);
  c_stop: cover property ($fell(o_sda_oe) && !o_scl_oe);
  c_wake: cover property ($rose(o_wake));
endmodule // imr_top_sva
bind imr_top imr_top_sva chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_scl(i_scl), .o_scl_out(o_scl_out),
  .o_scl_oe(o_scl_oe), .i_sleep(i_sleep), .o_wake(o_wake));

// [testbench/imr_slave_model.sv]
// Behavioural I2C slave: sends one byte MSB first and may stretch SCL
`timescale 1ns/10ps
module imr_slave_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bench control
  input wire logic [7:0] i_byte,
  input wire logic i_arm,
  input wire logic i_stretch,
  // Bus lines
  input wire logic i_scl,
  output logic o_sda_oe,
  output logic o_scl_oe
);
  logic scl_r;
  logic [3:0] cnt_r;
  logic [2:0] hold_r;
  wire logic scl_fall = scl_r && !i_scl;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_r <= 1'b1;
      cnt_r <= 4'hf;
      hold_r <= 3'h0;
    end else begin
      scl_r <= i_scl;
      if (i_arm) begin
        cnt_r <= 4'h0;
      end else if (scl_fall && cnt_r != 4'hf) begin
        cnt_r <= cnt_r + 4'h1;
      end
      if (scl_fall && i_stretch) begin
        hold_r <= 3'h7;
      end else if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
      end
    end
  end
  // Bits change only after a fall; released bits float high on the pull-up
  assign o_sda_oe = !cnt_r[3] && !i_byte[3'h7 - cnt_r[2:0]];
  // Holding longer than the low tick forces the master to wait
  assign o_scl_oe = hold_r != 3'h0;
endmodule // imr_slave_model

// [testbench/testbench.sv]
// Self-checking bench for the I2C master port
`timescale 1ns/10ps
`include "imr_consts.svh"
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [`IMR_ADDR_W-1:0] addr = 4'h0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic waitreq, sda_oe, scl_oe, m_sda_oe, m_scl_oe, wake, ak;
  logic sleep = 1'b0;
  logic tb_sda = 1'b0;
  logic arm = 1'b0;
  logic stretch = 1'b0;
  logic [7:0] byte_v = 8'h0;
  logic [7:0] b;
  int i;
  int fails = 0;
  int check_count = 0;
  wire logic sda = !(sda_oe || m_sda_oe || tb_sda);
  wire logic scl = !(scl_oe || m_scl_oe);
  always #4 i_clk = !i_clk;
  imr_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_scl(scl), .o_scl_out(), .o_scl_oe(scl_oe), .i_sleep(sleep), .o_wake(wake));
  imr_slave_model model_u (.i_clk(i_clk), .i_rst(i_rst), .i_byte(byte_v), .i_arm(arm),
    .i_stretch(stretch), .i_scl(scl), .o_sda_oe(m_sda_oe), .o_scl_oe(m_scl_oe));
  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= a;
    wdata <= {24'h0, d};
    rd_s <= !w;
    wr_s <= w;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic poll(input logic [3:0] a, input int bit_i, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 8'h0);
      n++;
    end while (q[bit_i] !== v && n < 400);
    chk(32'(q[bit_i]), 32'(v));
  endtask
  task automatic rx(input logic [7:0] d);
    bus(1'b1, `IMR_OFF_STAT, 8'h1e);
    byte_v <= d;
    arm <= 1'b1;
    @(posedge i_clk);
    arm <= 1'b0;
    bus(1'b1, `IMR_OFF_CTRL, 8'ha4);
    // A second launch while busy must not queue another byte
    bus(1'b1, `IMR_OFF_CTRL, 8'ha4);
    bus(1'b1, `IMR_OFF_BUF, ~d);
    poll(`IMR_OFF_STAT, `IMR_ST_IRQ, 1'b1);
    chk(32'(scl_oe), 32'h1);
    bus(1'b0, `IMR_OFF_CTRL, 8'h0);
    chk(q & 32'h4, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    q = $urandom(52103);
    bus(1'b0, `IMR_OFF_STAT, 8'h0);
    chk(q, 32'h0);
    bus(1'b0, `IMR_OFF_BAUD, 8'h0);
    chk(q, {24'h0, `IMR_BAUD_RST});
    bus(1'b0, 4'h6, 8'h0);
    chk(q, 32'h0);
    bus(1'b1, `IMR_OFF_BAUD, 8'h01);
    bus(1'b1, `IMR_OFF_CTRL, 8'ha0);
    bus(1'b1, `IMR_OFF_CTRL, 8'ha1);
    poll(`IMR_OFF_STAT, `IMR_ST_IRQ, 1'b1);
    for (i = 0; i < 4; i++) begin
      stretch <= i[0];
      b = 8'($urandom);
      ak = 1'($urandom);
      rx(b);
      sleep <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk(32'(wake), 32'h1);
      sleep <= 1'b0;
      bus(1'b0, `IMR_OFF_STAT, 8'h0);
      chk(q & 32'h1f, 32'h15);
      bus(1'b1, `IMR_OFF_STAT, 8'h1e);
      bus(1'b0, `IMR_OFF_BUF, 8'h0);
      chk(q, {24'h0, b});
      bus(1'b0, `IMR_OFF_STAT, 8'h0);
      chk(q & 32'h1, 32'h0);
      bus(1'b1, `IMR_OFF_CTRL, {3'h5, ak, 4'h8});
      repeat (3) @(posedge i_clk);
      chk(32'(sda_oe), 32'(!ak));
      poll(`IMR_OFF_CTRL, `IMR_CTL_ACKSEQ, 1'b0);
    end
    rx(8'h5a);
    rx(8'ha5);
    bus(1'b0, `IMR_OFF_STAT, 8'h0);
    chk(q & 32'h3, 32'h3);
    bus(1'b0, `IMR_OFF_BUF, 8'h0);
    bus(1'b1, `IMR_OFF_CTRL, 8'hb8);
    poll(`IMR_OFF_CTRL, `IMR_CTL_ACKSEQ, 1'b0);
    bus(1'b1, `IMR_OFF_STAT, 8'h1e);
    bus(1'b1, `IMR_OFF_CTRL, 8'ha2);
    poll(`IMR_OFF_STAT, `IMR_ST_STOPDET, 1'b1);
    poll(`IMR_OFF_STAT, `IMR_ST_IRQ, 1'b1);
    chk({30'h0, sda_oe, scl_oe}, 32'h0);
    bus(1'b1, `IMR_OFF_STAT, 8'h10);
    bus(1'b1, `IMR_OFF_CTRL, 8'ha1);
    poll(`IMR_OFF_STAT, `IMR_ST_IRQ, 1'b1);
    bus(1'b1, `IMR_OFF_STAT, 8'h10);
    bus(1'b1, `IMR_OFF_BUF, 8'hff);
    tb_sda <= 1'b1;
    poll(`IMR_OFF_STAT, `IMR_ST_BCOL, 1'b1);
    chk(q & 32'h1, 32'h0);
    chk({30'h0, sda_oe, scl_oe}, 32'h0);
    bus(1'b1, `IMR_OFF_STAT, 8'h10);
    @(posedge i_clk);
    tb_sda <= 1'b0;
    poll(`IMR_OFF_STAT, `IMR_ST_IRQ, 1'b1);
    bus(1'b1, `IMR_OFF_STAT, 8'h10);
    bus(1'b1, `IMR_OFF_CTRL, 8'ha1);
    poll(`IMR_OFF_STAT, `IMR_ST_IRQ, 1'b1);
    bus(1'b1, `IMR_OFF_CTRL, 8'ha4);
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    bus(1'b0, `IMR_OFF_CTRL, 8'h0);
    chk(q, 32'h0);
    bus(1'b0, `IMR_OFF_STAT, 8'h0);
    chk(q, 32'h0);
    report_and_stop();
  end
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule // testbench
